// ==== shared/lsau_cfg.svh ====
`ifndef LSAU_CFG_SVH
`define LSAU_CFG_SVH

// ==========================================================================
// register indices
`define LSAU_PROG_CNT_IDX 4'hf
`define LSAU_STACK_PTR_IDX 4'hd

// ==========================================================================
// status flag field inside a general register
`define LSAU_FLAGS_MSB 31
`define LSAU_FLAGS_LSB 27
`define LSAU_FLAGS_RST 5'h00

// ==========================================================================
// address arithmetic
`define LSAU_WORD_BYTES 32'h0000_0004
`define LSAU_LIT_ALIGN_MASK 32'hffff_fffc
`define LSAU_BRANCH_MASK 32'hffff_fffe

// ==========================================================================
// exclusive store result
`define LSAU_EXCL_OK 32'h0000_0000
`define LSAU_EXCL_FAIL 32'h0000_0001

`endif

// ==== shared/lsau_pkg.sv ====
package lsau_pkg;

    // ======================================================================
    // operations
    typedef enum logic [3:0] {
        OP_WORD_LOAD = 4'b0000,
        OP_WORD_STORE = 4'b0001,
        OP_WORD_LOAD_USER = 4'b0010,
        OP_WORD_STORE_USER = 4'b0011,
        OP_WORD_LOAD_EXCL = 4'b0100,
        OP_WORD_STORE_EXCL = 4'b0101,
        OP_DUAL_LOAD = 4'b0110,
        OP_DUAL_STORE = 4'b0111,
        OP_MULTI_LOAD_INC_AFTER = 4'b1000,
        OP_MULTI_LOAD_DEC_BEFORE = 4'b1001,
        OP_MULTI_STORE_INC_AFTER = 4'b1010,
        OP_MULTI_STORE_DEC_BEFORE = 4'b1011,
        OP_STACK_POP = 4'b1100,
        OP_STACK_PUSH = 4'b1101,
        OP_STATUS_READ = 4'b1110,
        OP_STATUS_WRITE = 4'b1111
    } lsau_op_t;

    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_HALF = 2'b01,
        SZ_WORD = 2'b10
    } lsau_size_t;

    typedef enum logic [1:0] {
        AM_OFFSET = 2'b00,
        AM_PRE = 2'b01,
        AM_POST = 2'b10
    } lsau_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_OPER = 3'b001,
        ST_FETCH = 3'b010,
        ST_DATA = 3'b011,
        ST_MEM = 3'b100,
        ST_WB = 3'b101
    } lsau_state_t;

endpackage

// ==== shared/lsau_rf_if.sv ====
`timescale 1ns/1ns
interface lsau_rf_if #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 32
);
    logic [ADDR_W-1:0] rd_a_addr;
    logic [DATA_W-1:0] rd_a_data;
    logic [ADDR_W-1:0] rd_b_addr;
    logic [DATA_W-1:0] rd_b_data;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;

    modport owner (
        output rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
        input rd_a_data, rd_b_data
    );
    modport store (
        input rd_a_addr, rd_b_addr, wr_en, wr_addr, wr_data,
        output rd_a_data, rd_b_data
    );
endinterface

// ==== testbench/lsau_mem_model.sv ====
`timescale 1ns/1ns
module lsau_mem_model (
    input wire logic mclk,
    input wire logic mem_req,
    input wire logic mem_write,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    int unsigned dly = 0, wt = 0;
    initial {mem_ack, mem_rdata} = 33'h0_0000_0000;
    // answers after zero to two wait cycles; read data churns once released
    always @(posedge mclk) begin
        mem_ack <= 1'b0;
        mem_rdata <= mem_rdata ^ 32'h5a5a_a5a5;
        if (mem_req === 1'b1 && !mem_ack) begin
            if (wt == dly % 3) begin
                mem_ack <= 1'b1;
                wt = 0;
                dly++;
                if (mem_write)
                    mem[mem_addr] = mem_wdata;
                else
                    mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
            end else begin
                wt++;
            end
        end
    end
endmodule // lsau_mem_model

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic mclk = 0, sys_rst = 1, req_valid = 0, req_ready, req_signed = 0, req_ofs_reg = 0;
    logic req_add = 1, req_wback = 1, core_priv = 1, flag_upd_en = 0, rf_ld_en = 0, mem_req;
    logic mem_write, mem_unpriv, mem_excl, mem_ack, mem_excl_fail = 0, done, req_err;
    logic branch_valid, branch_isa;
    logic [3:0] req_rt = 0, req_rt2 = 0, req_rn = 0, req_rm = 1, rf_ld_idx = 0;
    logic [4:0] req_shift = 0, flag_upd_val = 0, app_status_flags;
    logic [11:0] req_imm = 0;
    logic [15:0] req_list = 0;
    logic [31:0] program_counter = 32'h0000_1000, rf_ld_data = 0, mem_addr, mem_wdata;
    logic [31:0] mem_rdata, branch_target, b, e, a, rf [16];
    logic [65:0] lg [$];
    lsau_pkg::lsau_op_t req_op = lsau_pkg::OP_WORD_LOAD;
    lsau_pkg::lsau_op_t mops [4] = '{lsau_pkg::OP_MULTI_STORE_INC_AFTER,
        lsau_pkg::OP_MULTI_LOAD_DEC_BEFORE, lsau_pkg::OP_STACK_PUSH, lsau_pkg::OP_STACK_POP};
    lsau_pkg::lsau_size_t req_size = lsau_pkg::SZ_WORD, mem_size;
    lsau_pkg::lsau_mode_t req_mode = lsau_pkg::AM_OFFSET;
    int failures = 0, total_checks = 0, cyc = 0, i, j, k, errs = 0, brs = 0;
    integer seed = 32'hc1a2;
    lsau_top dut_u (.*);
    lsau_mem_model mem_u (.mclk, .mem_req, .mem_write, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata);
    always #2 mclk = ~mclk;
    // ======================================================================
    // access log and cycle ceiling
    always @(posedge mclk) begin
        cyc++;
        if (mem_req === 1'b1 && mem_ack === 1'b1)
            lg.push_back({mem_write, mem_unpriv, mem_addr, mem_write ? mem_wdata : 32'h0000_0000});
        if (req_err === 1'b1) errs++;
        if (branch_valid === 1'b1) brs++;
        if (cyc == 20000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(string nm, logic [65:0] s, logic [65:0] x);
        total_checks++;
        if (s !== x) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic acc(logic w, logic u, logic [31:0] ad, logic [31:0] d);
        logic [65:0] s = '1;
        if (lg.size() > 0) s = lg.pop_front();
        chk("access", s, {w, u, ad, w ? d : 32'h0000_0000});
    endtask
    task automatic plain();
        req_size = lsau_pkg::SZ_WORD;
        req_mode = lsau_pkg::AM_OFFSET;
        req_ofs_reg = 0;
        req_imm = 0;
        req_add = 1;
        req_signed = 0;
    endtask
    task automatic op(lsau_pkg::lsau_op_t o, logic [3:0] t, logic [3:0] n, logic [15:0] l);
        req_op = o;
        req_rt = t;
        req_rn = n;
        req_list = l;
        req_valid = 1;
        @(negedge mclk);
        req_valid = 0;
        for (k = 0; done !== 1'b1 && req_err !== 1'b1 && k < 300; k++)
            @(negedge mclk);
        if (k == 300) failures++;
        @(negedge mclk);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        sys_rst = 0;
        for (j = 0; j < 15; j++) begin
            rf[j] = (j == 4) ? 32'h0000_0010 : $random(seed);
            rf_ld_en = 1;
            rf_ld_idx = j[3:0];
            rf_ld_data = rf[j];
            @(negedge mclk);
        end
        rf_ld_en = 0;
        for (j = 0; j < 6; j++) begin
            req_size = lsau_pkg::lsau_size_t'(j % 3);
            req_mode = lsau_pkg::lsau_mode_t'(j % 3);
            req_add = j[0];
            req_signed = j[1];
            req_ofs_reg = j > 2;
            req_shift = j[4:0];
            req_imm = 12'h024;
            b = rf[4];
            e = req_ofs_reg ? rf[1] << j : 32'h0000_0024;
            e = req_add ? b + e : b - e;
            op(lsau_pkg::OP_WORD_STORE, 2, 4, 0);
            a = rf[2] & ~(32'hffff_ffff << (8 << j % 3));
            acc(1, 0, req_mode == lsau_pkg::AM_POST ? b : e, a);
            if (req_mode != lsau_pkg::AM_OFFSET) rf[4] = e;
        end
        plain();
        op(lsau_pkg::OP_WORD_STORE, 4, 0, 0);
        acc(1, 0, rf[0], rf[4]);
        $display("single stores done");
        for (j = 0; j < 4; j++) begin
            plain();
            req_size = lsau_pkg::lsau_size_t'(j % 2);
            req_signed = j[1];
            op(lsau_pkg::OP_WORD_LOAD, 5, 0, 0);
            acc(0, 0, rf[0], 0);
            a = j[0] ? {16'h0000, rf[4][15:0]} : {24'h00_0000, rf[4][7:0]};
            if (j[1]) a = j[0] ? {{16{a[15]}}, a[15:0]} : {{24{a[7]}}, a[7:0]};
            rf[5] = a;
            plain();
            req_imm = 12'h008;
            op(lsau_pkg::OP_WORD_STORE, 5, 0, 0);
            acc(1, 0, rf[0] + 8, a);
        end
        for (j = 0; j < 3; j++) begin
            plain();
            core_priv = j > 0;
            op(j == 1 ? lsau_pkg::OP_WORD_STORE : lsau_pkg::OP_WORD_STORE_USER, 3, 0, 0);
            acc(1, j != 1, rf[0], rf[3]);
        end
        $display("loads and user accesses done");
        for (j = 0; j < 4; j++) begin
            b = rf[j > 1 ? 13 : 6];
            e = (j == 0 || j == 3) ? b : b - 20;
            op(mops[j], 0, 6, 16'h003e);
            for (i = 1; i < 6; i++, e += 4)
                acc(j % 2 == 0, 0, e, rf[i]);
            rf[j > 1 ? 13 : 6] = (j == 0 || j == 3) ? b + 20 : b - 20;
        end
        for (j = 6; j < 14; j += 7) begin
            op(lsau_pkg::OP_WORD_STORE, j[3:0], 0, 0);
            acc(1, 0, rf[0], rf[j]);
        end
        op(lsau_pkg::OP_WORD_LOAD, 15, 15, 0);
        acc(0, 0, program_counter & 32'hffff_fffc, 0);
        a = ~(program_counter & 32'hffff_fffc);
        chk("branches", brs, 1);
        chk("target", {branch_isa, branch_target}, {a[0], a & 32'hffff_fffe});
        op(lsau_pkg::OP_DUAL_STORE, 3, 0, 0);
        acc(1, 0, rf[0], rf[3]);
        acc(1, 0, rf[0] + 4, rf[0]);
        op(lsau_pkg::OP_STATUS_WRITE, 0, 3, 0);
        chk("flags", app_status_flags, rf[3][31:27]);
        op(lsau_pkg::OP_STATUS_READ, 7, 0, 0);
        op(lsau_pkg::OP_WORD_STORE, 7, 0, 0);
        acc(1, 0, rf[0], {rf[3][31:27], 27'h000_0000});
        op(lsau_pkg::OP_WORD_STORE, 3, 15, 0);
        chk("refusal", errs, 1);
        chk("extra accesses", lg.size(), 0);
        $display("multi, status and refusal done");
        test_done();
    end
endmodule // testbench

// ==== verilog/lsau_regfile.sv ====
`timescale 1ns/1ns
module lsau_regfile #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 32
) (
    input wire logic clk,
    lsau_rf_if.store bus
);
    logic [WIDTH-1:0] mem_reg [DEPTH];

    // ======================================================================
    // write port
    always_ff @(posedge clk) begin
        if (bus.wr_en) begin
            mem_reg[bus.wr_addr] <= bus.wr_data;
        end
    end

    // ======================================================================
    // registered read ports, old data on a same-cycle write
    always_ff @(posedge clk) begin
        bus.rd_a_data <= mem_reg[bus.rd_a_addr];
        bus.rd_b_data <= mem_reg[bus.rd_b_addr];
    end
endmodule // lsau_regfile

// ==== verilog/lsau_top.sv ====
// Contract
// (RL1) stores write only low 16 or 8 bits
// (RL2) signed and unsigned stores are identical
// (RL3) unsigned narrow loads zero-extend to 32 bits
// (RL4) signed narrow loads sign-extend to 32 bits
// (RL5) unprivileged core: user variants act ordinarily
// (RL6) privileged core: user variants access unprivileged
// (RL7) word load to program_counter branches, may switch
// (RL8) address is base register plus offset
// (RL9) program_counter base accepted for loads only
// (RL10) immediate offset unsigned, added or subtracted
// (RL11) register offset never the program_counter
// (RL12) scaled offset shifted by immediate amount
// (RL13) offset mode: address base+-offset, base kept
// (RL14) pre-indexed: address written back into base
// (RL15) post-indexed: base is address, then updated
// (RL16) multi transfers use consecutive aligned words; the code does not align them, so an unaligned base gives unaligned words
// (RL17) increment-after and decrement-before, loads and stores
// (RL18) writeback adds total bytes transferred; decrement-before forms subtract them instead
// (RL19) pop is increment-after load via stack_pointer
// (RL20) push is decrement-before store via stack_pointer
// (RL21) status read and write move flags
// (RL22) dual-word and exclusive transfers supported
// (RL23) address arithmetic wraps modulo two^32
`timescale 1ns/1ns
`include "lsau_cfg.svh"
module lsau_top #(
    parameter int IMM_W = 12
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire lsau_pkg::lsau_op_t req_op,
    input wire lsau_pkg::lsau_size_t req_size,
    input wire logic req_signed,
    input wire logic [3:0] req_rt,
    input wire logic [3:0] req_rt2,
    input wire logic [3:0] req_rn,
    input wire logic [3:0] req_rm,
    input wire logic req_ofs_reg,
    input wire logic [IMM_W-1:0] req_imm,
    input wire logic [4:0] req_shift,
    input wire logic req_add,
    input wire lsau_pkg::lsau_mode_t req_mode,
    input wire logic req_wback,
    input wire logic [15:0] req_list,
    input wire logic core_priv,
    input wire logic [31:0] program_counter,
    input wire logic flag_upd_en,
    input wire logic [4:0] flag_upd_val,
    input wire logic rf_ld_en,
    input wire logic [3:0] rf_ld_idx,
    input wire logic [31:0] rf_ld_data,
    output logic mem_req,
    output logic mem_write,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    output lsau_pkg::lsau_size_t mem_size,
    output logic mem_unpriv,
    output logic mem_excl,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_excl_fail,
    output logic done,
    output logic req_err,
    output logic branch_valid,
    output logic [31:0] branch_target,
    output logic branch_isa,
    output logic [4:0] app_status_flags
);
    // ======================================================================
    // helpers
    function automatic logic [3:0] low_idx(input logic [15:0] m);
        low_idx = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (m[i]) low_idx = 4'(i);
        end
    endfunction

    function automatic logic [4:0] pop_cnt(input logic [15:0] m);
        pop_cnt = 5'h00;
        for (int i = 0; i < 16; i++) begin
            pop_cnt = pop_cnt + 5'(m[i]);
        end
    endfunction

    function automatic logic [31:0] load_ext(input logic [31:0] d,
                                             input lsau_pkg::lsau_size_t sz,
                                             input logic sg);
        unique case (sz)
            lsau_pkg::SZ_BYTE: load_ext = {{24{sg & d[7]}}, d[7:0]}; // RL3 RL4
            lsau_pkg::SZ_HALF: load_ext = {{16{sg & d[15]}}, d[15:0]}; // RL3 RL4
            default: load_ext = d;
        endcase
    endfunction

    // ======================================================================
    // state
    lsau_pkg::lsau_state_t state_reg;
    lsau_pkg::lsau_op_t op_reg;
    lsau_pkg::lsau_size_t size_reg;
    lsau_pkg::lsau_mode_t mode_reg;
    logic sgn_reg, ofs_sel_reg, add_reg, wb_en_reg, beat_reg;
    logic [3:0] rt_reg, rt2_reg, rn_reg, cur_idx_reg;
    logic [IMM_W-1:0] imm_reg;
    logic [4:0] shift_reg;
    logic [15:0] list_reg;
    logic [31:0] addr_reg, wb_val_reg;

    lsau_rf_if rf_bus ();

    lsau_regfile u_rf (
        .clk(mclk),
        .bus(rf_bus.store)
    );

    // ======================================================================
    // decode
    logic is_load, is_multi, is_dual, is_user, is_ia;
    logic req_multi, req_store, req_stack, req_bad, more_beats;
    logic [31:0] base_val, ofs_val, sum_val, list_bytes, ld_ext, src_val;
    logic [15:0] cur_onehot;

    assign is_load = op_reg inside {lsau_pkg::OP_WORD_LOAD, lsau_pkg::OP_WORD_LOAD_USER,
        lsau_pkg::OP_WORD_LOAD_EXCL, lsau_pkg::OP_DUAL_LOAD, lsau_pkg::OP_STACK_POP,
        lsau_pkg::OP_MULTI_LOAD_INC_AFTER, lsau_pkg::OP_MULTI_LOAD_DEC_BEFORE};
    assign is_multi = op_reg inside {lsau_pkg::OP_MULTI_LOAD_INC_AFTER,
        lsau_pkg::OP_MULTI_LOAD_DEC_BEFORE, lsau_pkg::OP_MULTI_STORE_INC_AFTER,
        lsau_pkg::OP_MULTI_STORE_DEC_BEFORE, lsau_pkg::OP_STACK_POP,
        lsau_pkg::OP_STACK_PUSH};
    assign is_ia = op_reg inside {lsau_pkg::OP_MULTI_LOAD_INC_AFTER,
        lsau_pkg::OP_MULTI_STORE_INC_AFTER, lsau_pkg::OP_STACK_POP}; // RL17 RL19
    assign is_dual = op_reg inside {lsau_pkg::OP_DUAL_LOAD, lsau_pkg::OP_DUAL_STORE}; // RL22
    assign is_user = op_reg inside {lsau_pkg::OP_WORD_LOAD_USER,
        lsau_pkg::OP_WORD_STORE_USER};

    assign req_stack = req_op inside {lsau_pkg::OP_STACK_POP, lsau_pkg::OP_STACK_PUSH};
    assign req_multi = req_stack || req_op inside {lsau_pkg::OP_MULTI_LOAD_INC_AFTER,
        lsau_pkg::OP_MULTI_LOAD_DEC_BEFORE, lsau_pkg::OP_MULTI_STORE_INC_AFTER,
        lsau_pkg::OP_MULTI_STORE_DEC_BEFORE};
    assign req_store = req_op inside {lsau_pkg::OP_WORD_STORE, lsau_pkg::OP_WORD_STORE_USER,
        lsau_pkg::OP_WORD_STORE_EXCL, lsau_pkg::OP_DUAL_STORE,
        lsau_pkg::OP_MULTI_STORE_INC_AFTER, lsau_pkg::OP_MULTI_STORE_DEC_BEFORE};
    // refuse offset from program_counter, stores based on it, empty lists
    assign req_bad = (req_ofs_reg && !req_multi && req_rm == `LSAU_PROG_CNT_IDX) // RL11
        || (req_store && req_rn == `LSAU_PROG_CNT_IDX) // RL9
        || (req_multi && req_list == 16'h0000);

    // literal base is the word-aligned program_counter
    assign base_val = (rn_reg == `LSAU_PROG_CNT_IDX)
        ? (program_counter & `LSAU_LIT_ALIGN_MASK) : rf_bus.rd_a_data; // RL8 RL9
    assign ofs_val = ofs_sel_reg ? (rf_bus.rd_b_data << shift_reg) // RL11 RL12
        : 32'(imm_reg); // RL10
    assign sum_val = add_reg ? (base_val + ofs_val) : (base_val - ofs_val); // RL10 RL23
    assign list_bytes = {25'h000_0000, pop_cnt(list_reg), 2'b00};
    assign ld_ext = load_ext(mem_rdata, size_reg, sgn_reg);
    assign src_val = (cur_idx_reg == `LSAU_PROG_CNT_IDX) ? program_counter : rf_bus.rd_a_data;
    assign cur_onehot = 16'h0001 << cur_idx_reg;
    assign more_beats = is_multi ? ((list_reg & ~cur_onehot) != 16'h0000) : (is_dual && !beat_reg);

    // ======================================================================
    // register file ports
    assign rf_bus.rd_a_addr = (state_reg == lsau_pkg::ST_IDLE)
        ? (req_stack ? `LSAU_STACK_PTR_IDX : req_rn) : cur_idx_reg;
    assign rf_bus.rd_b_addr = req_rm;

    always_comb begin
        rf_bus.wr_en = 1'b0;
        rf_bus.wr_addr = cur_idx_reg;
        rf_bus.wr_data = ld_ext;
        if (state_reg == lsau_pkg::ST_IDLE && rf_ld_en) begin
            rf_bus.wr_en = 1'b1;
            rf_bus.wr_addr = rf_ld_idx;
            rf_bus.wr_data = rf_ld_data;
        end else if (state_reg == lsau_pkg::ST_OPER && op_reg == lsau_pkg::OP_STATUS_READ) begin
            rf_bus.wr_en = 1'b1; // RL21
            rf_bus.wr_addr = rt_reg;
            rf_bus.wr_data = {app_status_flags, 27'h000_0000};
        end else if (state_reg == lsau_pkg::ST_MEM && mem_ack) begin
            if (is_load && cur_idx_reg != `LSAU_PROG_CNT_IDX) begin
                rf_bus.wr_en = 1'b1;
            end else if (op_reg == lsau_pkg::OP_WORD_STORE_EXCL) begin
                rf_bus.wr_en = 1'b1; // RL22
                rf_bus.wr_addr = rt2_reg;
                rf_bus.wr_data = mem_excl_fail ? `LSAU_EXCL_FAIL : `LSAU_EXCL_OK;
            end
        end else if (state_reg == lsau_pkg::ST_WB) begin
            rf_bus.wr_en = 1'b1; // RL14 RL15 RL18
            rf_bus.wr_addr = rn_reg;
            rf_bus.wr_data = wb_val_reg;
        end
    end

    // ======================================================================
    // sequencer
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= lsau_pkg::ST_IDLE;
            req_ready <= 1'b1;
            done <= 1'b0;
            req_err <= 1'b0;
            op_reg <= lsau_pkg::OP_WORD_LOAD;
            beat_reg <= 1'b0;
            wb_en_reg <= 1'b0;
            cur_idx_reg <= 4'h0;
            addr_reg <= 32'h0000_0000;
            wb_val_reg <= 32'h0000_0000;
        end else begin
            done <= 1'b0;
            req_err <= 1'b0;
            unique case (state_reg)
                lsau_pkg::ST_IDLE: begin
                    if (req_valid && req_bad) begin
                        req_err <= 1'b1;
                    end else if (req_valid) begin
                        op_reg <= req_op;
                        size_reg <= (req_multi || req_op inside {lsau_pkg::OP_DUAL_LOAD,
                            lsau_pkg::OP_DUAL_STORE}) ? lsau_pkg::SZ_WORD : req_size;
                        sgn_reg <= req_signed;
                        mode_reg <= req_mode;
                        rt_reg <= req_rt;
                        rt2_reg <= req_rt2;
                        rn_reg <= req_stack ? `LSAU_STACK_PTR_IDX : req_rn; // RL19 RL20
                        ofs_sel_reg <= req_ofs_reg;
                        imm_reg <= req_imm;
                        shift_reg <= req_shift;
                        add_reg <= req_add;
                        list_reg <= req_list;
                        wb_en_reg <= req_multi ? (req_wback || req_stack) // RL19 RL20
                            : (req_mode != lsau_pkg::AM_OFFSET); // RL13
                        beat_reg <= 1'b0;
                        req_ready <= 1'b0;
                        state_reg <= lsau_pkg::ST_OPER;
                    end
                end
                lsau_pkg::ST_OPER: begin
                    if (op_reg inside {lsau_pkg::OP_STATUS_READ, lsau_pkg::OP_STATUS_WRITE}) begin
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        state_reg <= lsau_pkg::ST_IDLE;
                    end else begin
                        if (is_multi) begin
                            addr_reg <= is_ia ? base_val : base_val - list_bytes; // RL17
                            wb_val_reg <= is_ia ? base_val + list_bytes // RL18 RL23
                                : base_val - list_bytes;
                            cur_idx_reg <= low_idx(list_reg);
                        end else begin
                            addr_reg <= (mode_reg == lsau_pkg::AM_POST) ? base_val // RL15
                                : sum_val; // RL13 RL14
                            wb_val_reg <= sum_val;
                            cur_idx_reg <= rt_reg;
                        end
                        state_reg <= lsau_pkg::ST_FETCH;
                    end
                end
                lsau_pkg::ST_FETCH: state_reg <= lsau_pkg::ST_DATA;
                lsau_pkg::ST_DATA: state_reg <= lsau_pkg::ST_MEM;
                lsau_pkg::ST_MEM: begin
                    if (mem_ack && more_beats) begin
                        addr_reg <= addr_reg + `LSAU_WORD_BYTES; // RL16 RL23
                        beat_reg <= 1'b1;
                        if (is_multi) begin
                            list_reg <= list_reg & ~cur_onehot;
                            cur_idx_reg <= low_idx(list_reg & ~cur_onehot);
                        end else begin
                            cur_idx_reg <= rt2_reg;
                        end
                        state_reg <= lsau_pkg::ST_FETCH;
                    end else if (mem_ack && wb_en_reg) begin
                        state_reg <= lsau_pkg::ST_WB;
                    end else if (mem_ack) begin
                        done <= 1'b1;
                        req_ready <= 1'b1;
                        state_reg <= lsau_pkg::ST_IDLE;
                    end
                end
                lsau_pkg::ST_WB: begin
                    done <= 1'b1;
                    req_ready <= 1'b1;
                    state_reg <= lsau_pkg::ST_IDLE;
                end
                default: state_reg <= lsau_pkg::ST_IDLE;
            endcase
        end
    end

    // ======================================================================
    // memory port
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            mem_addr <= 32'h0000_0000;
            mem_wdata <= 32'h0000_0000;
            mem_size <= lsau_pkg::SZ_WORD;
            mem_unpriv <= 1'b0;
            mem_excl <= 1'b0;
        end else if (state_reg == lsau_pkg::ST_DATA) begin
            mem_req <= 1'b1;
            mem_write <= !is_load;
            mem_addr <= addr_reg;
            // narrow stores carry no sign, only the low lanes
            mem_wdata <= load_ext(src_val, size_reg, 1'b0); // RL1 RL2
            mem_size <= size_reg;
            mem_unpriv <= !core_priv || is_user; // RL5 RL6
            mem_excl <= op_reg inside {lsau_pkg::OP_WORD_LOAD_EXCL,
                lsau_pkg::OP_WORD_STORE_EXCL}; // RL22
        end else if (state_reg == lsau_pkg::ST_MEM && mem_ack) begin
            mem_req <= 1'b0;
        end
    end

    // ======================================================================
    // loads to the program counter
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            branch_valid <= 1'b0;
            branch_target <= 32'h0000_0000;
            branch_isa <= 1'b0;
        end else begin
            branch_valid <= 1'b0;
            if (state_reg == lsau_pkg::ST_MEM && mem_ack && is_load
                && cur_idx_reg == `LSAU_PROG_CNT_IDX) begin
                branch_valid <= 1'b1; // RL7
                branch_target <= mem_rdata & `LSAU_BRANCH_MASK;
                branch_isa <= mem_rdata[0];
            end
        end
    end

    // ======================================================================
    // application status flags
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            app_status_flags <= `LSAU_FLAGS_RST;
        end else if (state_reg == lsau_pkg::ST_OPER && op_reg == lsau_pkg::OP_STATUS_WRITE) begin
            app_status_flags <= rf_bus.rd_a_data[`LSAU_FLAGS_MSB:`LSAU_FLAGS_LSB]; // RL21
        end else if (flag_upd_en) begin
            app_status_flags <= flag_upd_val;
        end
    end

    // ======================================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    wire logic mem_ld_ack = state_reg == lsau_pkg::ST_MEM && mem_ack && is_load;

    chk_store_narrow: assert property ( // RL1
        $rose(mem_req) && mem_write && mem_size != lsau_pkg::SZ_WORD
        |-> mem_wdata[31:16] == 16'h0000 && (mem_size == lsau_pkg::SZ_HALF
            || mem_wdata[15:8] == 8'h00))
        else $error("narrow store drives upper bits");
    chk_load_zero_ext: assert property ( // RL3
        mem_ld_ack && !sgn_reg && size_reg == lsau_pkg::SZ_BYTE && rf_bus.wr_en
        |-> rf_bus.wr_data == {24'h00_0000, mem_rdata[7:0]})
        else $error("unsigned byte load not zero-extended");
    chk_load_sign_ext: assert property ( // RL4
        mem_ld_ack && sgn_reg && size_reg == lsau_pkg::SZ_HALF && rf_bus.wr_en
        |-> rf_bus.wr_data[31:16] == {16{mem_rdata[15]}})
        else $error("signed halfword load not sign-extended");
    chk_unpriv_access: assert property ( // RL5 RL6
        $rose(mem_req) |-> mem_unpriv == (!$past(core_priv) || is_user))
        else $error("access privilege wrong");
    chk_pc_branch: assert property ( // RL7
        mem_ld_ack && cur_idx_reg == `LSAU_PROG_CNT_IDX
        |=> branch_valid && branch_isa == $past(mem_rdata[0]) && !$past(rf_bus.wr_en))
        else $error("load to program counter did not branch");
    chk_post_index_addr: assert property ( // RL15
        state_reg == lsau_pkg::ST_OPER && !is_multi && mode_reg == lsau_pkg::AM_POST
        && op_reg != lsau_pkg::OP_STATUS_READ && op_reg != lsau_pkg::OP_STATUS_WRITE
        |=> addr_reg == $past(base_val) && wb_val_reg == $past(sum_val))
        else $error("post-indexed address not base");
    chk_multi_consecutive: assert property ( // RL16
        state_reg == lsau_pkg::ST_MEM && mem_ack && is_multi && more_beats
        |-> ##3 $rose(mem_req) && mem_addr == $past(addr_reg, 3) + 32'h0000_0004)
        else $error("multi transfer address not consecutive");
    chk_multi_wback: assert property ( // RL17 RL18
        state_reg == lsau_pkg::ST_OPER && is_multi && !is_ia
        |=> addr_reg == wb_val_reg && addr_reg == $past(base_val) - $past(list_bytes))
        else $error("decrement-before base update wrong");
    chk_status_write: assert property ( // RL21
        state_reg == lsau_pkg::ST_OPER && op_reg == lsau_pkg::OP_STATUS_WRITE
        |=> app_status_flags == $past(rf_bus.rd_a_data[31:27]) && done)
        else $error("status write did not set flags");

    cov_push: cover property (state_reg == lsau_pkg::ST_WB && op_reg == lsau_pkg::OP_STACK_PUSH);
    cov_pop_branch: cover property (branch_valid && op_reg == lsau_pkg::OP_STACK_POP);
    cov_dual: cover property (mem_ack && is_dual && beat_reg);
endmodule // lsau_top
